/* File: rtl/qdc_pkg.sv */
// Constants and types for the quad DAC serial command decoder.
// Assumes a 100 MHz system clock; the serial link is sampled, not clocked.
`default_nettype none
package qdc_pkg;
	// ****************************************
	// Word layout
	// ****************************************
	localparam int WORD_BITS = 14;
	localparam int DATA_BITS = 8;
	localparam int CHANNELS = 4;
	localparam logic [3:0] CNT_HEAD_LAST = 4'h5; // Count before A0 is taken
	localparam logic [3:0] CNT_DATA_LAST = 4'hd; // Count before D0 is taken
	localparam logic [3:0] CNT_FULL = 4'he;
	localparam int MUTE_LSB = 4;
	localparam int SHUT_LSB = 0;
	localparam logic [1:0] CMD_STORE = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_READ = 2'h2;
	localparam logic [1:0] CMD_LOAD = 2'h3;
	localparam logic [2:0] ADDR_STATE = 3'h4;
	localparam logic [3:0] ALL_MUTED = 4'hf;
	localparam logic [3:0] NONE_SHUT = 4'h0;
	localparam logic [7:0] LEVEL_RESET = 8'h00;
	localparam logic [7:0] STATE_RESET = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLOCK_MHZ = 100;
	localparam int STORE_TIME_MS = 13;
	localparam int INIT_TIME_US = 80;
	localparam int STORE_CYCLES = STORE_TIME_MS * 1000 * CLOCK_MHZ;
	localparam int INIT_CYCLES = INIT_TIME_US * CLOCK_MHZ;
	// ****************************************
	// Power-on phases
	// ****************************************
	typedef enum logic [2:0] {
		QDC_INIT_LEVELS = 3'b001,
		QDC_INIT_STATE = 3'b010,
		QDC_RUN = 3'b100
	} qdc_phase_type;
	// Address names a channel register
	function automatic logic qdc_is_channel(input logic [2:0] addr);
		return addr < ADDR_STATE;
	endfunction
	// Address names any existing register
	function automatic logic qdc_is_target(input logic [2:0] addr);
		return addr <= ADDR_STATE;
	endfunction
endpackage
`default_nettype wire

/* File: rtl/qdc_serial_decoder.sv */
// Serial command decoder of a quad 8-bit DAC with nonvolatile backup.
// Link pins arrive asynchronously and are sampled by the system clock.
//
// How it works
// - Live and saved mute/shutdown bytes kept
// - Power-up copies saved state into live
// - Word: start, command, target, data, MSB first
// - Store 00 to channel saves its level
// - Store 00 target 4 saves state byte
// - Write 01 updates one channel level
// - Write 01 target 4 applies new state
// - Read 10 shows saved byte on output
// - Load 11 copies saved level to live
// - Load 11 target 4 restores live state
// - Output shifts during the same word
// - Output floats until valid read header
// - Bits sampled on rising clock, select low
// - Select high: link ignored, output floats
// - Ready flag reports nonvolatile memory state
// - Ready low from store header until done
// - Store ignored while all channels off
// - Read byte shifts over following eight clocks
// - Start-up mutes outputs, levels then state
`default_nettype none
module qdc_serial_decoder #(
	parameter int STORE_CYCLES_P = qdc_pkg::STORE_CYCLES,
	parameter int INIT_CYCLES_P = qdc_pkg::INIT_CYCLES,
	parameter logic [7:0] SAVED_LEVEL_INIT = qdc_pkg::LEVEL_RESET,
	parameter logic [7:0] SAVED_STATE_INIT = qdc_pkg::STATE_RESET
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic serial_clock,
	input wire logic select_b,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	output logic memory_ready_flag_out,
	output logic memory_ready_flag_oe,
	output logic [7:0] channel0_analog_level,
	output logic [7:0] channel1_analog_level,
	output logic [7:0] channel2_analog_level,
	output logic [7:0] channel3_analog_level,
	output logic [3:0] channel_mute,
	output logic [3:0] channel_shutdown,
	output logic interface_enabled
);
	import qdc_pkg::*;

	localparam int SW = $clog2(STORE_CYCLES_P + 1);
	localparam int IW = $clog2(INIT_CYCLES_P + 1);

	// ****************************************
	// Pin synchronisers and edge finding
	// ****************************************
	logic clk_s1, clk_s2, clk_s3;
	logic sel_s1, sel_s2;
	logic din_s1, din_s2;

	// Two flops per pin; a third on the clock only to find edges
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			clk_s1 <= 1'b0;
			clk_s2 <= 1'b0;
			clk_s3 <= 1'b0;
			sel_s1 <= 1'b1;
			sel_s2 <= 1'b1;
			din_s1 <= 1'b0;
			din_s2 <= 1'b0;
		end else begin
			clk_s1 <= serial_clock;
			clk_s2 <= clk_s1;
			clk_s3 <= clk_s2;
			sel_s1 <= select_b;
			sel_s2 <= sel_s1;
			din_s1 <= serial_in;
			din_s2 <= din_s1;
		end
	end

	qdc_phase_type phase;
	logic link_rise, link_fall, link_on;
	assign link_rise = clk_s2 & ~clk_s3;
	assign link_fall = ~clk_s2 & clk_s3;
	// Link works only after start-up and while selected
	assign link_on = (phase == QDC_RUN) && !sel_s2;

	// ****************************************
	// Word shifter
	// ****************************************
	logic [3:0] bit_cnt;
	logic [12:0] rx;
	logic [12:0] next_rx;
	logic busy;
	logic take_bit;
	assign next_rx = {rx[11:0], din_s2};
	// Leading zeros are skipped until a start bit; no new word while storing
	assign take_bit = link_rise && link_on && (bit_cnt != CNT_FULL)
		&& !(bit_cnt == 4'h0 && (!din_s2 || busy));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bit_cnt <= 4'h0;
		end else if (!link_on) begin
			bit_cnt <= 4'h0;
		end else if (take_bit) begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Extra clocks beyond fourteen bits are ignored
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx <= 13'h0;
		end else if (take_bit && bit_cnt != 4'h0) begin
			rx <= next_rx;
		end
	end

	logic hdr_event, data_event;
	logic [1:0] hdr_cmd;
	logic [2:0] hdr_addr;
	logic [1:0] word_cmd;
	logic [2:0] word_addr;
	logic [7:0] word_data;
	assign hdr_event = take_bit && bit_cnt == CNT_HEAD_LAST;
	assign data_event = take_bit && bit_cnt == CNT_DATA_LAST;
	assign hdr_cmd = next_rx[4:3];
	assign hdr_addr = next_rx[2:0];
	assign word_cmd = next_rx[12:11];
	assign word_addr = next_rx[10:8];
	assign word_data = next_rx[7:0];

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0] saved_level [CHANNELS];
	logic [7:0] live_level [CHANNELS];
	logic [7:0] saved_channel_state;
	logic [7:0] live_channel_state;
	logic all_off;
	logic store_go, store_commit, store_have;
	logic [2:0] store_addr;
	logic [7:0] store_data;
	logic [SW-1:0] store_tmr;
	logic [IW-1:0] init_tmr;

	// Every channel muted or shut down blocks stores
	assign all_off = &(live_channel_state[MUTE_LSB +: 4] | live_channel_state[SHUT_LSB +: 4]);
	assign store_go = hdr_event && hdr_cmd == CMD_STORE && qdc_is_target(hdr_addr)
		&& !all_off;
	assign store_commit = busy && store_tmr == '0 && store_have;

	// Start-up sequencer: levels first, state byte last
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase <= QDC_INIT_LEVELS;
			init_tmr <= IW'(INIT_CYCLES_P - 1);
		end else begin
			unique case (phase)
				QDC_INIT_LEVELS: begin
					init_tmr <= init_tmr - IW'(1);
					if (init_tmr == IW'(INIT_CYCLES_P / 2)) begin
						phase <= QDC_INIT_STATE;
					end
				end
				QDC_INIT_STATE: begin
					init_tmr <= init_tmr - IW'(1);
					if (init_tmr == '0) begin
						phase <= QDC_RUN;
					end
				end
				QDC_RUN: begin
					init_tmr <= '0;
				end
			endcase
		end
	end

	// Store engine; memory busy from the header until programming ends
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			store_tmr <= '0;
			store_addr <= 3'h0;
			store_data <= 8'h00;
			store_have <= 1'b0;
		end else if (store_go) begin
			busy <= 1'b1;
			store_tmr <= SW'(STORE_CYCLES_P - 1);
			store_addr <= hdr_addr;
			store_have <= 1'b0;
		end else if (busy) begin
			store_tmr <= store_tmr - SW'(store_tmr != '0);
			if (store_tmr == '0) begin
				busy <= 1'b0;
			end
			// A word cut short before D0 stores nothing
			if (data_event && word_cmd == CMD_STORE) begin
				store_data <= word_data;
				store_have <= 1'b1;
			end
		end
	end

	// Nonvolatile bytes change only when programming completes
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < CHANNELS; i++) begin
				saved_level[i] <= SAVED_LEVEL_INIT;
			end
			saved_channel_state <= SAVED_STATE_INIT;
		end else if (store_commit) begin
			if (qdc_is_channel(store_addr)) begin
				saved_level[store_addr[1:0]] <= store_data;
			end else begin
				saved_channel_state <= store_data;
			end
		end
	end

	// Volatile channel levels, one generate slice per channel
	for (genvar g = 0; g < CHANNELS; g++) begin : g_live
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				live_level[g] <= LEVEL_RESET;
			end else if (phase == QDC_INIT_LEVELS && init_tmr == IW'(INIT_CYCLES_P / 2)) begin
				live_level[g] <= saved_level[g];
			end else if (data_event && word_cmd == CMD_WRITE && word_addr == 3'(g)) begin
				live_level[g] <= word_data;
			end else if (hdr_event && hdr_cmd == CMD_LOAD && hdr_addr == 3'(g)) begin
				live_level[g] <= saved_level[g];
			end
		end
	end

	// Volatile operating state
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			live_channel_state <= STATE_RESET;
		end else if (phase == QDC_INIT_STATE && init_tmr == '0) begin
			live_channel_state <= saved_channel_state;
		end else if (data_event && word_cmd == CMD_WRITE && word_addr == ADDR_STATE) begin
			live_channel_state <= word_data;
		end else if (hdr_event && hdr_cmd == CMD_LOAD && hdr_addr == ADDR_STATE) begin
			live_channel_state <= saved_channel_state;
		end
	end

	// ****************************************
	// Read-back path
	// ****************************************
	logic [7:0] tx;

	// Driven from the header of a valid read until select rises
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			serial_out_oe <= 1'b0;
			serial_out <= 1'b0;
			tx <= 8'h00;
		end else if (sel_s2) begin
			serial_out_oe <= 1'b0;
		end else if (hdr_event && hdr_cmd == CMD_READ && qdc_is_target(hdr_addr)) begin
			serial_out_oe <= 1'b1;
			tx <= qdc_is_channel(hdr_addr) ? saved_level[hdr_addr[1:0]] : saved_channel_state;
		end else if (serial_out_oe && link_fall) begin
			// Falling edges give the host a full half period of setup
			serial_out <= tx[7];
			tx <= {tx[6:0], 1'b0};
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			channel0_analog_level <= LEVEL_RESET;
			channel1_analog_level <= LEVEL_RESET;
			channel2_analog_level <= LEVEL_RESET;
			channel3_analog_level <= LEVEL_RESET;
			channel_mute <= ALL_MUTED;
			channel_shutdown <= NONE_SHUT;
			interface_enabled <= 1'b0;
		end else begin
			channel0_analog_level <= live_level[0];
			channel1_analog_level <= live_level[1];
			channel2_analog_level <= live_level[2];
			channel3_analog_level <= live_level[3];
			channel_mute <= (phase != QDC_RUN) ? ALL_MUTED
				: live_channel_state[MUTE_LSB +: 4];
			channel_shutdown <= (phase != QDC_RUN) ? NONE_SHUT
				: live_channel_state[SHUT_LSB +: 4];
			interface_enabled <= (phase == QDC_RUN);
		end
	end

	// Open drain: pull low while the memory is busy
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			memory_ready_flag_out <= 1'b0;
			memory_ready_flag_oe <= 1'b0;
		end else begin
			memory_ready_flag_out <= 1'b0;
			memory_ready_flag_oe <= busy;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence read_header_s;
		hdr_event && hdr_cmd == CMD_READ && qdc_is_target(hdr_addr) && !sel_s2;
	endsequence
	sequence first_fall_s;
		##[1:40] (link_fall && !sel_s2);
	endsequence

	read_drive_a: assert property (read_header_s |=> serial_out_oe)
		else $error("read header did not enable serial output");
	read_msb_a: assert property (read_header_s |=> first_fall_s ##1
		(serial_out == $past(tx[7]) || sel_s2))
		else $error("read byte not shifted on falling edge");
	float_idle_a: assert property (sel_s2 |=> !serial_out_oe)
		else $error("serial output driven while deselected");
	held_idle_a: assert property (!link_on |=> bit_cnt == 4'h0)
		else $error("bits counted while link disabled");
	busy_low_a: assert property (store_go |=> ##1 memory_ready_flag_oe [*3])
		else $error("ready flag not low after store header");
	store_block_a: assert property (hdr_event && all_off |=> !busy || $past(busy))
		else $error("store accepted while all channels off");
	write_level_a: assert property (data_event && word_cmd == CMD_WRITE && word_addr == 3'h0
		|=> ##1 channel0_analog_level == $past(word_data, 2))
		else $error("channel 0 level not written");
	init_mute_a: assert property (phase != QDC_RUN |=> channel_mute == ALL_MUTED)
		else $error("outputs not muted during start-up");
	state_apply_a: assert property ($past(phase) == QDC_RUN && phase == QDC_RUN
		|=> channel_mute == $past(live_channel_state[MUTE_LSB +: 4]))
		else $error("mute outputs do not follow live state");
	bad_target_a: assert property (hdr_event && !qdc_is_target(hdr_addr)
		|=> $stable(live_channel_state) && !serial_out_oe)
		else $error("unused target changed state");
endmodule // qdc_serial_decoder
`default_nettype wire

/* File: dv/qdc_host_model.sv */
// Host side of the serial link: frames whole 14-bit words and gathers read bits.
// Assumes the device samples the link with its own clock; link clock is 125 ns.
`default_nettype none
module qdc_host_model (
	output logic serial_clock,
	output logic select_b,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic dout_line;
	// A floating output shows the inverse level, so a stale bit never passes
	assign dout_line = serial_out_oe ? serial_out : ~serial_out;
	// Idle link: clock parked low, device not selected
	initial begin
		serial_clock = 1'b0;
		select_b = 1'b1;
		serial_in = 1'b0;
	end
	// One word MSB first; sel high sends the same pulses to a deselected device
	task automatic xfer(input logic [13:0] word, input logic sel, output logic [7:0] rd,
		output logic oe_seen);
		rd = 8'h00;
		oe_seen = 1'b0;
		select_b = sel;
		#150;
		for (int i = 13; i >= 0; i--) begin
			serial_in = word[i];
			#62.5;
			if (i <= 7) rd = {rd[6:0], dout_line};
			oe_seen = oe_seen | serial_out_oe;
			serial_clock = 1'b1;
			#62.5;
			serial_clock = 1'b0;
		end
		#62.5;
		oe_seen = oe_seen | serial_out_oe;
		select_b = 1'b1;
		serial_in = ~serial_in;
		#250;
	endtask
endmodule // qdc_host_model
`default_nettype wire

/* File: dv/quad_dac_serial_command_decoder_test.sv */
// Self-checking bench: host model drives words, a register model predicts results.
// Assumes short store and start-up counts; ready line has a pull-up.
`default_nettype none
module quad_dac_serial_command_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;
	import qdc_pkg::*;
	// ****************************************
	// Set-up
	// ****************************************
	localparam int STORE_N = 200;
	localparam int INIT_N = 20;
	localparam logic [7:0] LVL0 = 8'h5a;
	localparam logic [7:0] ST0 = 8'h00;
	localparam logic [1:0] ORDER [4] = '{CMD_WRITE, CMD_STORE, CMD_READ, CMD_LOAD};
	logic clock, rst_b, serial_clock, select_b, serial_in, serial_out, serial_out_oe;
	logic ready_out, ready_oe, ready_line, if_en;
	logic [7:0] lvl [4];
	logic [3:0] mute, shut;
	logic [7:0] saved [5];
	logic [7:0] live [5];
	logic [15:0] lfsr_state;
	int miscompares, check_count;
	// Open-drain ready line with its pull-up
	assign ready_line = ready_oe ? ready_out : 1'b1;
	qdc_serial_decoder #(.STORE_CYCLES_P(STORE_N), .INIT_CYCLES_P(INIT_N),
		.SAVED_LEVEL_INIT(LVL0), .SAVED_STATE_INIT(ST0)) dut (
		.clock(clock), .rst_b(rst_b), .serial_clock(serial_clock), .select_b(select_b),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.memory_ready_flag_out(ready_out), .memory_ready_flag_oe(ready_oe),
		.channel0_analog_level(lvl[0]), .channel1_analog_level(lvl[1]),
		.channel2_analog_level(lvl[2]), .channel3_analog_level(lvl[3]),
		.channel_mute(mute), .channel_shutdown(shut), .interface_enabled(if_en));
	qdc_host_model host (.serial_clock(serial_clock), .select_b(select_b),
		.serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic stop_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Every live output against the model
	task automatic compare_all();
		for (int c = 0; c < CHANNELS; c++) check("level", lvl[c], live[c]);
		check("mute", {4'h0, mute}, {4'h0, live[4][7:4]});
		check("shutdown", {4'h0, shut}, {4'h0, live[4][3:0]});
	endtask
	// One word through the host, then the model's view of its effect
	task automatic run(input logic [1:0] cmd, input logic [2:0] addr, input logic [7:0] data,
		input logic sel);
		logic [7:0] rd;
		logic oe_seen;
		logic ok;
		ok = !sel && addr <= ADDR_STATE;
		@(posedge clock);
		#1;
		host.xfer({1'b1, cmd, addr, data}, sel, rd, oe_seen);
		check("out_enable", {7'h0, oe_seen}, {7'h0, ok && cmd == CMD_READ});
		if (ok && cmd == CMD_READ) check("read_data", rd, saved[addr]);
		if (ok && cmd == CMD_WRITE) live[addr] = data;
		if (ok && cmd == CMD_LOAD) live[addr] = saved[addr];
		if (ok && cmd == CMD_STORE) begin
			// Store refused while every channel is muted or shut down
			ok = (live[4][7:4] | live[4][3:0]) != ALL_MUTED;
			check("busy", {7'h0, ready_line}, {7'h0, !ok});
			if (ok) saved[addr] = data;
			// Next word only after the ready line is back high
			for (int n = 0; n < STORE_N + 100 && ready_line !== 1'b1; n++) @(posedge clock);
			#1;
			check("ready_back", {7'h0, ready_line}, 8'h01);
		end
		compare_all();
	endtask
	// ****************************************
	// Clock, watchdog, sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Normal run is about 24k cycles; 60k means a hang
	initial begin
		repeat (60000) @(posedge clock);
		miscompares++;
		stop_test();
	end
	initial begin
		rst_b = 1'b0;
		miscompares = 0;
		check_count = 0;
		lfsr_state = 16'h86f8;
		for (int i = 0; i < 4; i++) saved[i] = LVL0;
		saved[4] = ST0;
		live = saved;
		repeat (8) @(posedge clock);
		#1 rst_b = 1'b1;
		@(posedge clock);
		#1;
		check("mute_start", {4'h0, mute}, {4'h0, ALL_MUTED});
		check("enable_start", {7'h0, if_en}, 8'h00);
		repeat (INIT_N + 4) @(posedge clock);
		#1;
		check("enable_run", {7'h0, if_en}, 8'h01);
		compare_all();
		// Every command against every target, random data
		for (int rep = 0; rep < 3; rep++) begin
			for (int k = 0; k < 4; k++) begin
				for (int a = 0; a < 8; a++) begin
					lfsr_state = lfsr_next(lfsr_state);
					run(ORDER[k], a[2:0], lfsr_state[7:0], 1'b0);
				end
			end
		end
		// All channels off: store dropped, saved byte kept
		run(CMD_WRITE, ADDR_STATE, 8'hf0, 1'b0);
		run(CMD_STORE, 3'h0, 8'h33, 1'b0);
		run(CMD_READ, 3'h0, 8'h00, 1'b0);
		run(CMD_WRITE, ADDR_STATE, 8'h00, 1'b0);
		// Pulses with select high leave everything alone
		run(CMD_WRITE, 3'h1, 8'hc3, 1'b1);
		run(CMD_LOAD, ADDR_STATE, 8'h00, 1'b0);
		stop_test();
	end
endmodule // quad_dac_serial_command_decoder_test
`default_nettype wire
